// [rtl/lin_assist_regs.svh]
`ifndef LIN_ASSIST_REGS_SVH
`define LIN_ASSIST_REGS_SVH
// Operation
// - Master: timer start drives transmit pin low for the programmed timer period.
// - Master underflow releases transmit pin, sets break flag, interrupts if enabled.
// - Master then sends synch byte 55h through the companion UART.
// - Master then sends identifier through the UART, then response field follows.
// - Writing break detect start masks UART receive and arms timer; reads zero.
// - Slave: receive low for timer period is a break; flag, interrupt, measure.
// - Slave measures start bit plus data bits 0 to 6 with the timer.
// - Unmask select: 0 unmasks after break, 1 after synch measurement.
// - Synch measurement done sets field flag, interrupts if field enable set.
// - With UART transmit on, pin mismatch at latch point sets collision flag.
// - During communication, receive low beyond break period signals a break again.
// - Four interrupt sources all share the timer interrupt request line.
// - Mode bit: 0 slave with break detection, 1 master with timer on transmit.
// - Run bit stops logic at 0, starts at 1 and masks inputs at once.
// - Receive status flag reads 0 while unmasked and 1 while masked.

// Register indices; byte address is four times the index
`define LIN_CONTROL_IDX 10'h106
`define LIN_STATUS_IDX 10'h107
`define TIMER_PRESCALER_IDX 10'h108
`define TIMER_COUNT_IDX 10'h109
`define TIMER_CONTROL_IDX 10'h10a

// Control field positions
`define CTL_FIELD_IRQ_EN 0
`define CTL_BREAK_IRQ_EN 1
`define CTL_COLLISION_IRQ_EN 2
`define CTL_RX_STATUS 3
`define CTL_BREAK_DETECT_START 4
`define CTL_UNMASK_SELECT 5
`define CTL_MASTER_SELECT 6
`define CTL_RUN 7

// Status field positions, flags are write-one-to-clear
`define ST_BREAK 0
`define ST_FIELD 1
`define ST_COLLISION 2
`define ST_MEAS_LSB 8
`define ST_MEAS_MSB 15

`define TMR_START 0
`define TIMER_PRESCALER_RESET 8'h00
`define TIMER_COUNT_RESET 8'h00
// Falling edges counted after the start bit when the next one closes the measured span
`define SYNCH_LAST_FALL 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [rtl/lin_assist_pkg.sv]
package lin_assist_pkg;
  typedef enum logic [2:0] {
    IDLE = 3'b000,
    M_BREAK = 3'b001,
    M_SEND = 3'b010,
    S_WAIT = 3'b011,
    S_BREAK_END = 3'b100,
    S_START = 3'b101,
    S_MEASURE = 3'b110,
    COMM = 3'b111
  } header_state_type;
endpackage

// [rtl/lin_timer_if.sv]
`timescale 1ns/10ps
interface lin_timer_if;
  logic run;
  logic load;
  logic [7:0] pre_reload;
  logic [7:0] cnt_reload;
  logic underflow;
  logic [7:0] count;
  modport timer (input run, load, pre_reload, cnt_reload, output underflow, count);
  modport ctrl (output run, load, pre_reload, cnt_reload, input underflow, count);
endinterface

// [rtl/lin_pin_sync.sv]
`timescale 1ns/10ps
module lin_pin_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic level_out
);
  logic [2:0] stage;

  // Three stages; the level moves only when stages two and three agree
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stage <= 3'h7;
      level_out <= 1'b1;
    end else begin
      stage <= {stage[1:0], pin_in};
      if (stage[1] == stage[2]) begin
        level_out <= stage[2];
      end
    end
  end
endmodule // lin_pin_sync

// [rtl/lin_break_timer.sv]
`timescale 1ns/10ps
module lin_break_timer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  lin_timer_if.timer tmr
);
  logic [7:0] pre;
  logic terminal;

  assign terminal = (pre == 8'h00) && (tmr.count == 8'h00);

  // Prescaler feeds the count; one period is (pre+1)*(count+1) clocks
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pre <= 8'h00;
      tmr.count <= 8'h00;
    end else if (tmr.load) begin
      pre <= tmr.pre_reload;
      tmr.count <= tmr.cnt_reload;
    end else if (tmr.run) begin
      if (pre == 8'h00) begin
        pre <= tmr.pre_reload;
        tmr.count <= (tmr.count == 8'h00) ? tmr.cnt_reload : tmr.count - 8'h01;
      end else begin
        pre <= pre - 8'h01;
      end
    end
  end

  // Underflow pulse, one cycle after the terminal count
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tmr.underflow <= 1'b0;
    end else begin
      tmr.underflow <= tmr.run && !tmr.load && terminal;
    end
  end
endmodule // lin_break_timer

// [rtl/lin_header_assist.sv]
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "lin_assist_regs.svh"
module lin_header_assist #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [ADDR_WIDTH-1:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [ADDR_WIDTH-1:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  input wire logic LIN_RX_PIN_IN,
  output logic LIN_TX_PIN_OUT,
  input wire logic UART_TXD_IN,
  input wire logic UART_TX_ENABLE_IN,
  input wire logic UART_LATCH_IN,
  output logic UART_RXD_OUT,
  output logic TIMER_IRQ_OUT
);
  lin_assist_pkg::header_state_type state;
  lin_assist_pkg::header_state_type next_state;
  lin_timer_if tmr ();
  logic aw_held, w_held, wr_go, wr_ctl, wr_st, wr_tc, break_start, timer_go;
  logic [9:0] aw_idx;
  logic [9:0] ar_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic field_irq_enable, break_irq_enable, collision_irq_enable;
  logic unmask_timing_select, master_select, run_enable, run_prev;
  logic rx_masked, rx_level, rx_prev, rx_fall;
  logic break_status_flag, field_status_flag, collision_status_flag;
  logic brk_evt, gen_evt, meas_done, coll_evt;
  logic [1:0] falls;
  logic [7:0] meas_count;
  logic [7:0] timer_prescaler_reg;
  logic [7:0] timer_count_reg;

  lin_pin_sync rx_sync (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .pin_in(LIN_RX_PIN_IN),
    .level_out(rx_level)
  );

  lin_break_timer break_timer (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .tmr(tmr.timer)
  );

  // Write channel: address and data are taken independently, in either order
  assign AXI_AWREADY_OUT = !aw_held;
  assign AXI_WREADY_OUT = !w_held;
  assign wr_go = aw_held && w_held && !AXI_BVALID_OUT;
  assign wr_ctl = wr_go && (aw_idx == `LIN_CONTROL_IDX) && w_strb[0];
  assign wr_st = wr_go && (aw_idx == `LIN_STATUS_IDX) && w_strb[0];
  assign wr_tc = wr_go && (aw_idx == `TIMER_CONTROL_IDX) && w_strb[0];

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 10'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (AXI_AWVALID_IN && !aw_held) begin
        aw_held <= 1'b1;
        aw_idx <= AXI_AWADDR_IN[11:2];
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (AXI_WVALID_IN && !w_held) begin
        w_held <= 1'b1;
        w_data <= AXI_WDATA_IN;
        w_strb <= AXI_WSTRB_IN;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped words answer SLVERR and change nothing
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT <= `RESP_OKAY;
    end else if (wr_go) begin
      AXI_BVALID_OUT <= 1'b1;
      AXI_BRESP_OUT <= (aw_idx >= `LIN_CONTROL_IDX && aw_idx <= `TIMER_CONTROL_IDX) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (AXI_BREADY_IN) begin
      AXI_BVALID_OUT <= 1'b0;
    end
  end

  // Read channel: one read at a time, data registered with the answer
  assign AXI_ARREADY_OUT = !AXI_RVALID_OUT;
  assign ar_idx = AXI_ARADDR_IN[11:2];

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      AXI_RVALID_OUT <= 1'b0;
      AXI_RDATA_OUT <= 32'h0000_0000;
      AXI_RRESP_OUT <= `RESP_OKAY;
    end else if (AXI_ARVALID_IN && !AXI_RVALID_OUT) begin
      AXI_RVALID_OUT <= 1'b1;
      AXI_RRESP_OUT <= `RESP_OKAY;
      unique case (ar_idx)
        `LIN_CONTROL_IDX: AXI_RDATA_OUT <= {24'h00_0000, run_enable, master_select, unmask_timing_select,
          1'b0, rx_masked, collision_irq_enable, break_irq_enable, field_irq_enable};
        `LIN_STATUS_IDX: AXI_RDATA_OUT <= {16'h0000, meas_count, 5'h00, collision_status_flag,
          field_status_flag, break_status_flag};
        `TIMER_PRESCALER_IDX: AXI_RDATA_OUT <= {24'h00_0000, timer_prescaler_reg};
        `TIMER_COUNT_IDX: AXI_RDATA_OUT <= {24'h00_0000, tmr.count};
        `TIMER_CONTROL_IDX: AXI_RDATA_OUT <= {31'h0000_0000, state == lin_assist_pkg::M_BREAK};
        default: begin
          AXI_RDATA_OUT <= 32'h0000_0000;
          AXI_RRESP_OUT <= `RESP_SLVERR;
        end
      endcase
    end else if (AXI_RREADY_IN) begin
      AXI_RVALID_OUT <= 1'b0;
    end
  end

  // Control bits; break detect start is an action, never stored
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      field_irq_enable <= 1'b0;
      break_irq_enable <= 1'b0;
      collision_irq_enable <= 1'b0;
      unmask_timing_select <= 1'b0;
      master_select <= 1'b0;
      run_enable <= 1'b0;
    end else if (wr_ctl) begin
      field_irq_enable <= w_data[`CTL_FIELD_IRQ_EN];
      break_irq_enable <= w_data[`CTL_BREAK_IRQ_EN];
      collision_irq_enable <= w_data[`CTL_COLLISION_IRQ_EN];
      unmask_timing_select <= w_data[`CTL_UNMASK_SELECT];
      master_select <= w_data[`CTL_MASTER_SELECT];
      run_enable <= w_data[`CTL_RUN];
    end
  end

  // Timer reload values, reprogrammed by software after measurement
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      timer_prescaler_reg <= `TIMER_PRESCALER_RESET;
      timer_count_reg <= `TIMER_COUNT_RESET;
    end else if (wr_go && w_strb[0]) begin
      if (aw_idx == `TIMER_PRESCALER_IDX) begin
        timer_prescaler_reg <= w_data[7:0];
      end
      if (aw_idx == `TIMER_COUNT_IDX) begin
        timer_count_reg <= w_data[7:0];
      end
    end
  end

  assign break_start = wr_ctl && w_data[`CTL_BREAK_DETECT_START] && w_data[`CTL_RUN] && !w_data[`CTL_MASTER_SELECT];
  assign timer_go = wr_tc && w_data[`TMR_START] && run_enable && master_select;
  assign rx_fall = rx_prev && !rx_level;

  // Timer steering: it times the break out or in, then the synch span
  assign tmr.pre_reload = timer_prescaler_reg;
  assign tmr.cnt_reload = timer_count_reg;
  assign tmr.load = timer_go || break_start || (state == lin_assist_pkg::S_START && rx_fall)
    || ((state == lin_assist_pkg::S_WAIT || state == lin_assist_pkg::COMM) && rx_level);
  assign tmr.run = (state == lin_assist_pkg::M_BREAK) || (state == lin_assist_pkg::S_MEASURE)
    || ((state == lin_assist_pkg::S_WAIT || state == lin_assist_pkg::COMM) && !rx_level);

  // Events from the sequence and the pins
  assign gen_evt = (state == lin_assist_pkg::M_BREAK) && tmr.underflow;
  assign brk_evt = (state == lin_assist_pkg::S_WAIT || state == lin_assist_pkg::COMM) && tmr.underflow;
  assign meas_done = (state == lin_assist_pkg::S_MEASURE) && rx_fall && (falls == `SYNCH_LAST_FALL);
  assign coll_evt = run_enable && UART_TX_ENABLE_IN && UART_LATCH_IN && (rx_level != LIN_TX_PIN_OUT);

  // Header sequence; clearing run drops straight back to idle
  always_comb begin
    next_state = state;
    unique case (state)
      lin_assist_pkg::IDLE: next_state = state;
      lin_assist_pkg::M_BREAK: if (tmr.underflow) next_state = lin_assist_pkg::M_SEND;
      lin_assist_pkg::M_SEND: next_state = state;
      lin_assist_pkg::S_WAIT: if (tmr.underflow) next_state = lin_assist_pkg::S_BREAK_END;
      lin_assist_pkg::S_BREAK_END: if (rx_level) next_state = lin_assist_pkg::S_START;
      lin_assist_pkg::S_START: if (rx_fall) next_state = lin_assist_pkg::S_MEASURE;
      lin_assist_pkg::S_MEASURE: if (meas_done) next_state = lin_assist_pkg::COMM;
      lin_assist_pkg::COMM: next_state = state;
    endcase
    if (timer_go) begin
      next_state = lin_assist_pkg::M_BREAK;
    end
    if (break_start) begin
      next_state = lin_assist_pkg::S_WAIT;
    end
    // Start may come in the very write that sets run, so it must not be lost to the stop
    if (!run_enable && !break_start) begin
      next_state = lin_assist_pkg::IDLE;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state <= lin_assist_pkg::IDLE;
      rx_prev <= 1'b1;
      run_prev <= 1'b0;
    end else begin
      state <= next_state;
      rx_prev <= rx_level;
      run_prev <= run_enable;
    end
  end

  // Falling edges of the synch byte; the fifth one ends bit six
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      falls <= 2'h0;
      meas_count <= 8'h00;
    end else if (state != lin_assist_pkg::S_MEASURE) begin
      falls <= 2'h0;
    end else if (rx_fall) begin
      falls <= falls + 2'h1;
      if (meas_done) begin
        meas_count <= tmr.count;
      end
    end
  end

  // Receive mask: set when run starts and at break detect start
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      rx_masked <= 1'b0;
    end else if (!run_enable && !break_start) begin
      rx_masked <= 1'b0;
    end else if ((!run_prev) || break_start) begin
      rx_masked <= 1'b1;
    end else if (gen_evt || meas_done) begin
      rx_masked <= 1'b0;
    end else if (state == lin_assist_pkg::S_WAIT && tmr.underflow && !unmask_timing_select) begin
      rx_masked <= 1'b0;
    end
  end

  // Sticky flags; a new event in the clearing cycle wins
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      break_status_flag <= 1'b0;
      field_status_flag <= 1'b0;
      collision_status_flag <= 1'b0;
    end else begin
      break_status_flag <= brk_evt || gen_evt || (break_status_flag && !(wr_st && w_data[`ST_BREAK]));
      field_status_flag <= meas_done || (field_status_flag && !(wr_st && w_data[`ST_FIELD]));
      collision_status_flag <= coll_evt || (collision_status_flag && !(wr_st && w_data[`ST_COLLISION]));
    end
  end

  // One shared request line for all four sources
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      TIMER_IRQ_OUT <= 1'b0;
    end else begin
      TIMER_IRQ_OUT <= ((brk_evt || gen_evt) && break_irq_enable) || (meas_done && field_irq_enable)
        || (coll_evt && collision_irq_enable);
    end
  end

  // Pins: the break drives low over the UART line; masked receive idles high
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      LIN_TX_PIN_OUT <= 1'b1;
      UART_RXD_OUT <= 1'b1;
    end else begin
      LIN_TX_PIN_OUT <= UART_TXD_IN && (state != lin_assist_pkg::M_BREAK);
      UART_RXD_OUT <= rx_masked || rx_level;
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence master_break_end;
    state == lin_assist_pkg::M_BREAK && tmr.underflow;
  endsequence

  sequence synch_measured;
    field_status_flag && state == lin_assist_pkg::COMM && !rx_masked;
  endsequence

  AST_BREAK_LOW: assert property (state == lin_assist_pkg::M_BREAK |=> !LIN_TX_PIN_OUT)
    else $error("transmit pin not low during break");
  AST_BREAK_RELEASE: assert property (master_break_end |=> (state == lin_assist_pkg::M_SEND && break_status_flag)
    ##1 (LIN_TX_PIN_OUT == $past(UART_TXD_IN)))
    else $error("break end did not release pin and flag");
  AST_BREAK_IRQ: assert property ((brk_evt || gen_evt) && break_irq_enable |=> TIMER_IRQ_OUT)
    else $error("break interrupt missing");
  AST_START_READS_ZERO: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT && ar_idx == `LIN_CONTROL_IDX
    |=> !AXI_RDATA_OUT[`CTL_BREAK_DETECT_START])
    else $error("break detect start read back as one");
  AST_MASK_ON_START: assert property (break_start |=> rx_masked [*2])
    else $error("receive not masked after break detect start");
  AST_SLAVE_BREAK: assert property (state == lin_assist_pkg::S_WAIT && tmr.underflow
    |=> break_status_flag && state == lin_assist_pkg::S_BREAK_END)
    else $error("slave break not recognised");
  AST_UNMASK_EARLY: assert property (state == lin_assist_pkg::S_WAIT && tmr.underflow && !unmask_timing_select
    && run_enable |=> !rx_masked)
    else $error("receive still masked after break");
  AST_FIELD_DONE: assert property (meas_done && !wr_ctl |=> synch_measured)
    else $error("synch measurement end wrong");
  AST_COLLISION: assert property (coll_evt |=> collision_status_flag)
    else $error("collision not flagged");
  AST_STOP: assert property (!run_enable && !break_start |=> state == lin_assist_pkg::IDLE && !rx_masked)
    else $error("run clear did not stop the logic");
  AST_MASKED_IDLE: assert property ($rose(rx_masked) |=> UART_RXD_OUT)
    else $error("masked receive not held high");
endmodule // lin_header_assist

// [test/lin_bus_node.sv]
`timescale 1ns/10ps
module lin_bus_node (
  input wire logic clk_in,
  input wire logic tx_pin_in,
  output logic rx_pin_out
);
  logic node_drive_n = 1'b1;

  // Wired-AND bus with pull-up, so a released node shows high, never a stale level
  assign rx_pin_out = tx_pin_in & node_drive_n;

  // Pull the bus low for n clocks, a break when long enough
  task automatic hold_low(input int n);
    @(posedge clk_in);
    node_drive_n <= 1'b0;
    repeat (n) @(posedge clk_in);
    node_drive_n <= 1'b1;
  endtask

  // One UART frame, start bit first, lsb first, bt clocks a bit
  task automatic send_byte(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      node_drive_n <= f[i];
      repeat (bt - 1) @(posedge clk_in);
    end
  endtask
endmodule // lin_bus_node

// [test/lin_header_assist_test.sv]
`timescale 1ns/10ps
`include "lin_assist_regs.svh"
module lin_header_assist_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic uart_txd = 1'b1;
  logic uart_tx_en = 1'b0;
  logic latch = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rx_pin, tx_pin, uart_rxd, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] ident;
  int errors = 0;
  int n_tests = 0;
  int n_irq = 0;
  int exp_irq = 0;
  int cnt, lo;

  always #2.5 clk = ~clk;

  lin_header_assist dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
    .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hf), .AXI_WVALID_IN(wvalid),
    .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
    .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
    .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .LIN_RX_PIN_IN(rx_pin),
    .LIN_TX_PIN_OUT(tx_pin), .UART_TXD_IN(uart_txd), .UART_TX_ENABLE_IN(uart_tx_en), .UART_LATCH_IN(latch),
    .UART_RXD_OUT(uart_rxd), .TIMER_IRQ_OUT(irq));

  lin_bus_node node (.clk_in(clk), .tx_pin_in(tx_pin), .rx_pin_out(rx_pin));

  // Each interrupt pulse lasts one cycle, so count at every edge
  always @(posedge clk) if (irq === 1'b1) n_irq <= n_irq + 1;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Handshakes are sampled just before the edge, since inputs only move after edges
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic sa, sw, sb;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    sb = 1'b0;
    while (!sb) begin
      @(negedge clk);
      sa = awready;
      sw = wready;
      sb = bvalid;
      r = bresp;
      @(posedge clk);
      if (sa) awvalid <= 1'b0;
      if (sw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    check({30'h0, r}, {30'h0, er});
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [1:0] er, input logic [31:0] m, input logic [31:0] e);
    logic sa, sv;
    logic [1:0] r;
    logic [31:0] d;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    sv = 1'b0;
    while (!sv) begin
      @(negedge clk);
      sa = arready;
      sv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (sa) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    check({30'h0, r}, {30'h0, er});
    check(d & m, e);
  endtask

  // UART frame on the transmit side, 8 clocks a bit, latch late in the bit
  task automatic uart_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      uart_txd <= f[i];
      repeat (5) @(posedge clk);
      latch <= 1'b1;
      @(negedge clk);
      check({31'h0, tx_pin}, {31'h0, f[i]});
      @(posedge clk);
      latch <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Far node pulls low while we send high, latch lands inside the low
  task automatic collide();
    fork
      node.hold_low(8);
      begin
        repeat (5) @(posedge clk);
        latch <= 1'b1;
        @(posedge clk);
        latch <= 1'b0;
      end
    join
    repeat (4) @(posedge clk);
  endtask

  task automatic results();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog, far beyond the several hundred cycles the tests need
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    results();
  end

  initial begin
    void'($urandom(32'h7b391e65));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`LIN_CONTROL_IDX, `RESP_OKAY, 32'hffffffff, 32'h0);
    rchk(`LIN_STATUS_IDX, `RESP_OKAY, 32'h7, 32'h0);
    rchk(10'h000, `RESP_SLVERR, 32'hffffffff, 32'h0);
    wr(10'h000, 32'hff, `RESP_SLVERR);
    wr(`TIMER_PRESCALER_IDX, 32'h3, `RESP_OKAY);
    wr(`TIMER_COUNT_IDX, 32'h7, `RESP_OKAY);
    // Slave header twice, unmasking after break and after synch
    for (int sel = 0; sel < 2; sel++) begin
      wr(`LIN_CONTROL_IDX, 32'h0, `RESP_OKAY);
      wr(`LIN_CONTROL_IDX, 32'h93 | 32'(sel << 5), `RESP_OKAY);
      rchk(`LIN_CONTROL_IDX, `RESP_OKAY, 32'hff, 32'h8b | 32'(sel << 5));
      check({31'h0, uart_rxd}, 32'h1);
      node.hold_low(48);
      repeat (10) @(posedge clk);
      rchk(`LIN_CONTROL_IDX, `RESP_OKAY, 32'h8, 32'(sel << 3));
      rchk(`LIN_STATUS_IDX, `RESP_OKAY, 32'h7, 32'h1);
      node.send_byte(8'h55, 3);
      repeat (10) @(posedge clk);
      rchk(`LIN_CONTROL_IDX, `RESP_OKAY, 32'h8, 32'h0);
      rchk(`LIN_STATUS_IDX, `RESP_OKAY, 32'hff07, 32'h0203);
      wr(`LIN_STATUS_IDX, 32'h3, `RESP_OKAY);
      rchk(`LIN_STATUS_IDX, `RESP_OKAY, 32'h7, 32'h0);
      exp_irq += 2;
    end
    wr(`TIMER_COUNT_IDX, 32'h7, `RESP_OKAY);
    node.hold_low(48);
    repeat (10) @(posedge clk);
    rchk(`LIN_STATUS_IDX, `RESP_OKAY, 32'h7, 32'h1);
    exp_irq += 1;
    // Master header with a random count and identifier
    cnt = 4 + int'($urandom % 8);
    ident = 8'($urandom);
    wr(`LIN_CONTROL_IDX, 32'h0, `RESP_OKAY);
    wr(`LIN_STATUS_IDX, 32'h7, `RESP_OKAY);
    wr(`TIMER_PRESCALER_IDX, 32'h1, `RESP_OKAY);
    wr(`TIMER_COUNT_IDX, 32'(cnt), `RESP_OKAY);
    wr(`LIN_CONTROL_IDX, 32'hc6, `RESP_OKAY);
    rchk(`LIN_CONTROL_IDX, `RESP_OKAY, 32'hff, 32'hce);
    wr(`TIMER_CONTROL_IDX, 32'h1, `RESP_OKAY);
    lo = 0;
    for (int i = 0; i < 300 && (lo == 0 || tx_pin === 1'b0); i++) begin
      @(negedge clk);
      if (tx_pin === 1'b0) lo++;
    end
    check(32'(lo >= 2 * (cnt + 1) - 1 && lo <= 2 * (cnt + 1) + 2), 32'h1);
    repeat (4) @(posedge clk);
    rchk(`LIN_STATUS_IDX, `RESP_OKAY, 32'h7, 32'h1);
    rchk(`TIMER_CONTROL_IDX, `RESP_OKAY, 32'hffffffff, 32'h0);
    rchk(`TIMER_COUNT_IDX, `RESP_OKAY, 32'hffffffff, 32'(cnt));
    rchk(`TIMER_PRESCALER_IDX, `RESP_OKAY, 32'hffffffff, 32'h1);
    uart_tx_en <= 1'b1;
    uart_byte(8'h55);
    uart_byte(ident);
    rchk(`LIN_STATUS_IDX, `RESP_OKAY, 32'h7, 32'h1);
    wr(`LIN_STATUS_IDX, 32'h1, `RESP_OKAY);
    exp_irq += 1;
    collide();
    rchk(`LIN_STATUS_IDX, `RESP_OKAY, 32'h7, 32'h4);
    wr(`LIN_STATUS_IDX, 32'h4, `RESP_OKAY);
    exp_irq += 1;
    uart_tx_en <= 1'b0;
    collide();
    rchk(`LIN_STATUS_IDX, `RESP_OKAY, 32'h7, 32'h0);
    wr(`LIN_CONTROL_IDX, 32'h0, `RESP_OKAY);
    repeat (4) @(posedge clk);
    check(32'(n_irq), 32'(exp_irq));
    results();
  end
endmodule // lin_header_assist_test
